//--- core/cpac_pkg.sv
package cpac_pkg;

	// register map
	localparam logic [7:0] CTRL_OFFSET = 8'h01;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] CTRL_WMASK  = 8'h3A;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;

	// field positions
	localparam int SOFT_RESET_BIT = 7;
	localparam int WAVE_SEL_HI    = 5;
	localparam int WAVE_SEL_LO    = 4;
	localparam int MOD_ENABLE_BIT = 3;
	localparam int LOOPBACK_BIT   = 1;

	// waveform select codes
	localparam logic [1:0] WAVE_DELTA_SIGMA = 2'h0;
	localparam logic [1:0] WAVE_BALANCED    = 2'h1;
	localparam logic [1:0] WAVE_TRAILING    = 2'h2;
	localparam logic [1:0] WAVE_RESERVED    = 2'h3;

	// timing
	localparam int CLK_HZ      = 10000000;
	localparam int BAL_RATE_HZ = 16000;
	localparam int TRL_RATE_HZ = 32000;
	localparam int BAL_PERIOD_CYC = CLK_HZ / BAL_RATE_HZ;
	localparam int TRL_PERIOD_CYC = CLK_HZ / TRL_RATE_HZ;

	// audio widths
	localparam int AUDIO_W = 16;
	localparam int LEVEL_W = AUDIO_W + 1;
	localparam int PHASE_W = 10;

endpackage

//--- core/cpac_period_div.sv
`timescale 1ns/1ps
`default_nettype none
module cpac_period_div #(
	parameter int PERIOD = 625
) (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// period position
	output logic [cpac_pkg::PHASE_W-1:0] phase,
	output logic                         tick
);
	import cpac_pkg::*;

	localparam logic [PHASE_W-1:0] LAST = PHASE_W'(PERIOD - 1);

	logic [PHASE_W-1:0] phase_q;
	logic [PHASE_W-1:0] phase_d;

	always_comb begin
		if (phase_q == LAST) begin
			phase_d = '0;
		end else begin
			phase_d = phase_q + PHASE_W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			phase_q <= '0;
		end else begin
			phase_q <= phase_d;
		end
	end

	assign phase = phase_q;
	assign tick  = (phase_q == '0);
endmodule
`default_nettype wire

//--- core/cpac_dsm.sv
`timescale 1ns/1ps
`default_nettype none
module cpac_dsm (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// offset-binary level in, bitstream out
	input  wire logic [cpac_pkg::LEVEL_W-1:0] level,
	output logic                              bitOut
);
	import cpac_pkg::*;

	logic [LEVEL_W-1:0] acc_q;
	logic [LEVEL_W-1:0] acc_d;
	logic               bit_q;
	logic               bit_d;

	// first order: carry of the accumulator is the output bit
	always_comb begin
		{bit_d, acc_d} = {1'b0, acc_q} + {1'b0, level};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= '0;
			bit_q <= 1'b0;
		end else begin
			acc_q <= acc_d;
			bit_q <= bit_d;
		end
	end

	assign bitOut = bit_q;
endmodule
`default_nettype wire

//--- core/cpac_top.sv
// Behaviour
// (R1) writing soft reset one resets all registers
// (R2) soft reset bit clears itself
// (R3) unused bits 6, 2, 0 read zero
// (R4) bits 5:4 select waveform, 11 reserved
// (R5) code 00 gives delta-sigma bitstream
// (R6) ones density follows summed audio level
// (R7) code 01 gives balanced centred PWM
// (R8) code 10 falls at period start, rises proportionally
// (R9) enable bit sums TX and RX onto pin
// (R10) enable zero keeps waveform off the pin
// (R11) bit 1 enables loopback across the barrier
// (R12) host powers line side, off-hook before loopback
// (R13) looped data passes through both filters
// (R14) waveform only when pin function select zero
// (R15) soft reset is one-cycle pulse resetting flops
`timescale 1ns/1ps
`default_nettype none
module cpac_top (
	// clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	// register port
	input  wire logic [7:0]                   regAddr,
	input  wire logic [7:0]                   regWdata,
	input  wire logic                         regWrite,
	input  wire logic                         regRead,
	output logic      [7:0]                   regRdata,
	// audio paths
	input  wire logic [cpac_pkg::AUDIO_W-1:0] txAudio,
	input  wire logic [cpac_pkg::AUDIO_W-1:0] rxAudio,
	input  wire logic [cpac_pkg::AUDIO_W-1:0] txFiltered,
	input  wire logic [cpac_pkg::AUDIO_W-1:0] linkRxData,
	output logic      [cpac_pkg::AUDIO_W-1:0] rxFilterIn,
	output logic                              loopbackActive,
	// shared pin
	input  wire logic                         pinFunctionSelect,
	input  wire logic                         interruptLevel,
	output logic                              callProgressOut,
	output logic                              callProgressOutEn,
	// soft reset to the rest of the register file
	output logic                              softResetPulse
);
	import cpac_pkg::*;

	localparam logic [PHASE_W-1:0] BAL_PERIOD = PHASE_W'(BAL_PERIOD_CYC);
	localparam logic [PHASE_W-1:0] TRL_PERIOD = PHASE_W'(TRL_PERIOD_CYC);
	localparam logic [LEVEL_W-1:0] LEVEL_MID  = {1'b1, {AUDIO_W{1'b0}}};
	localparam int                 PROD_W     = LEVEL_W + PHASE_W;

	// register block state
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       srPulse_q;
	logic       srPulse_d;
	logic       blockRst;

	// control register port
	always_comb begin
		ctrl_d    = ctrl_q;
		srPulse_d = 1'b0;
		rdata_d   = UNMAPPED_RD;
		if (regWrite && regAddr == CTRL_OFFSET) begin
			if (regWdata[SOFT_RESET_BIT]) begin
				ctrl_d    = CTRL_RESET; // R1
				srPulse_d = 1'b1; // R15
			end else begin
				ctrl_d = regWdata & CTRL_WMASK; // R2
			end
		end
		if (regRead && regAddr == CTRL_OFFSET) begin
			rdata_d = ctrl_q & CTRL_WMASK; // R3
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			srPulse_q <= 1'b0;
		end else begin
			srPulse_q <= srPulse_d; // R15
		end
	end

	// the pulse clears every flop of the block except its own for one cycle
	assign blockRst = rst | srPulse_q; // R1

	always_ff @(posedge clk) begin
		if (blockRst) begin
			ctrl_q  <= CTRL_RESET;
			rdata_q <= UNMAPPED_RD;
		end else begin
			ctrl_q  <= ctrl_d;
			rdata_q <= rdata_d;
		end
	end

	logic [1:0] waveSel;
	logic       modEnable;
	logic       loopEnable;

	assign waveSel    = ctrl_q[WAVE_SEL_HI:WAVE_SEL_LO]; // R4
	assign modEnable  = ctrl_q[MOD_ENABLE_BIT];
	assign loopEnable = ctrl_q[LOOPBACK_BIT];

	// summed audio as offset binary
	logic signed [LEVEL_W-1:0] sumSigned;
	logic        [LEVEL_W-1:0] levelNow;

	always_comb begin
		sumSigned = LEVEL_W'($signed(txAudio)) + LEVEL_W'($signed(rxAudio)); // R9
		levelNow  = LEVEL_W'(sumSigned) ^ LEVEL_MID;
	end

	// period dividers
	logic [PHASE_W-1:0] balPhase;
	logic               balTick;
	logic [PHASE_W-1:0] trlPhase;
	logic               trlTick;

	cpac_period_div #(
		.PERIOD(BAL_PERIOD_CYC)
	) u_bal_div (
		.clk   (clk),
		.rst   (blockRst),
		.phase (balPhase),
		.tick  (balTick)
	);

	cpac_period_div #(
		.PERIOD(TRL_PERIOD_CYC)
	) u_trl_div (
		.clk   (clk),
		.rst   (blockRst),
		.phase (trlPhase),
		.tick  (trlTick)
	);

	logic dsmBit;

	cpac_dsm u_dsm (
		.clk    (clk),
		.rst    (blockRst),
		.level  (levelNow), // R6
		.bitOut (dsmBit)
	);

	// sample latches, one per pwm period
	logic [LEVEL_W-1:0] balLevel_q;
	logic [LEVEL_W-1:0] balLevel_d;
	logic [LEVEL_W-1:0] trlLevel_q;
	logic [LEVEL_W-1:0] trlLevel_d;

	always_comb begin
		balLevel_d = balTick ? levelNow : balLevel_q;
		trlLevel_d = trlTick ? levelNow : trlLevel_q;
	end

	always_ff @(posedge clk) begin
		if (blockRst) begin
			balLevel_q <= LEVEL_MID;
			trlLevel_q <= LEVEL_MID;
		end else begin
			balLevel_q <= balLevel_d;
			trlLevel_q <= trlLevel_d;
		end
	end

	// pulse edges from the latched level
	logic [PROD_W-1:0]  balProd;
	logic [PROD_W-1:0]  trlProd;
	logic [PHASE_W-1:0] balHalf;
	logic [PHASE_W-1:0] trlRise;
	logic               balBit;
	logic               trlBit;
	logic               waveBit;

	always_comb begin
		balProd = PROD_W'(balLevel_q) * PROD_W'(BAL_PERIOD);
		trlProd = PROD_W'(trlLevel_q) * PROD_W'(TRL_PERIOD);
		balHalf = {1'b0, balProd[PROD_W-1:LEVEL_W+1]};
		trlRise = trlProd[PROD_W-1:LEVEL_W];
		// high part centred on the tick, low part centred half a period later
		balBit  = (balPhase < balHalf) || (balPhase >= BAL_PERIOD - balHalf); // R7
		// low from period start until the proportional rise point
		trlBit  = (trlPhase != '0) && (trlPhase >= trlRise); // R8
		unique case (waveSel)
			WAVE_DELTA_SIGMA: waveBit = dsmBit; // R5
			WAVE_BALANCED:    waveBit = balBit; // R7
			WAVE_TRAILING:    waveBit = trlBit; // R8
			WAVE_RESERVED:    waveBit = 1'b0; // R4
		endcase
	end

	// shared pin and loopback path
	logic                pin_q;
	logic                pin_d;
	logic                pinEn_q;
	logic                pinEn_d;
	logic                loop_q;
	logic                loop_d;
	logic [AUDIO_W-1:0]  rxIn_q;
	logic [AUDIO_W-1:0]  rxIn_d;

	always_comb begin
		if (pinFunctionSelect) begin
			pin_d   = interruptLevel; // R14
			pinEn_d = 1'b1;
		end else begin
			pin_d   = modEnable & waveBit; // R9
			pinEn_d = modEnable; // R10
		end
		loop_d = loopEnable; // R11
		// loopback takes the filtered tx word into the rx filter input
		rxIn_d = loopEnable ? txFiltered : linkRxData; // R13
	end

	always_ff @(posedge clk) begin
		if (blockRst) begin
			pin_q   <= 1'b0;
			pinEn_q <= 1'b0;
			loop_q  <= 1'b0;
			rxIn_q  <= '0;
		end else begin
			pin_q   <= pin_d;
			pinEn_q <= pinEn_d;
			loop_q  <= loop_d;
			rxIn_q  <= rxIn_d;
		end
	end

	assign regRdata          = rdata_q;
	assign callProgressOut   = pin_q;
	assign callProgressOutEn = pinEn_q;
	assign loopbackActive    = loop_q;
	assign rxFilterIn        = rxIn_q;
	assign softResetPulse    = srPulse_q;
endmodule
`default_nettype wire

//--- dv/cpac_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpac_checker (
	// clock, reset, register port
	input wire logic                         clk,
	input wire logic                         rst,
	input wire logic [7:0]                   regAddr,
	input wire logic [7:0]                   regWdata,
	input wire logic                         regWrite,
	input wire logic                         regRead,
	input wire logic [7:0]                   regRdata,
	// audio and pin
	input wire logic [cpac_pkg::AUDIO_W-1:0] txAudio,
	input wire logic [cpac_pkg::AUDIO_W-1:0] rxAudio,
	input wire logic [cpac_pkg::AUDIO_W-1:0] txFiltered,
	input wire logic [cpac_pkg::AUDIO_W-1:0] linkRxData,
	input wire logic [cpac_pkg::AUDIO_W-1:0] rxFilterIn,
	input wire logic                         loopbackActive,
	input wire logic                         pinFunctionSelect,
	input wire logic                         interruptLevel,
	input wire logic                         callProgressOut,
	input wire logic                         callProgressOutEn,
	input wire logic                         softResetPulse
);
	import cpac_pkg::*;
	logic [7:0] ctrlQ;
	logic [7:0] ctrlD;
	logic       dsOn;
	// shadow of the control register; accesses in the pulse cycle are lost
	always_comb begin
		ctrlD = ctrlQ;
		if (regWrite && regAddr == CTRL_OFFSET)
			ctrlD = regWdata[SOFT_RESET_BIT] ? CTRL_RESET : (regWdata & CTRL_WMASK);
	end
	always_ff @(posedge clk) begin
		ctrlQ <= (rst || softResetPulse) ? CTRL_RESET : ctrlD;
	end
	assign dsOn = ctrlQ[5:4] == WAVE_DELTA_SIGMA && ctrlQ[3] && !pinFunctionSelect;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_SR: assert property (
		regWrite && regAddr == CTRL_OFFSET && regWdata[7] && !softResetPulse
		|=> softResetPulse ##1 !softResetPulse) else $error("soft reset pulse");
	AST_RD: assert property (
		regRead && regAddr == CTRL_OFFSET && !softResetPulse |=> regRdata == $past(ctrlQ))
		else $error("control readback");
	AST_UNMAP: assert property (
		regRead && regAddr != CTRL_OFFSET |=> regRdata == UNMAPPED_RD) else $error("unmapped read");
	AST_LOOP: assert property (
		!$past(rst) && !$past(softResetPulse) |-> loopbackActive == $past(ctrlQ[1]) &&
		rxFilterIn == ($past(ctrlQ[1]) ? $past(txFiltered) : $past(linkRxData)))
		else $error("loopback path");
	AST_EN: assert property (
		!$past(rst) && !$past(softResetPulse)
		|-> callProgressOutEn == ($past(pinFunctionSelect) || $past(ctrlQ[3])))
		else $error("pin enable");
	AST_INT: assert property (
		!$past(rst) && !$past(softResetPulse) && $past(pinFunctionSelect)
		|-> callProgressOut == $past(interruptLevel)) else $error("interrupt role");
	AST_OFF: assert property (
		!callProgressOutEn |-> !callProgressOut) else $error("released pin driven");
	AST_RSV: assert property (
		(ctrlQ[5:4] == WAVE_RESERVED && !pinFunctionSelect)[*3] |-> !callProgressOut)
		else $error("reserved code drives pin");
	AST_DS: assert property (
		(dsOn && txAudio == 16'h0000 && rxAudio == 16'h0000)[*6]
		|-> callProgressOut != $past(callProgressOut)) else $error("mid-scale bitstream");
	AST_TRL: assert property (
		(ctrlQ[5:4] == WAVE_TRAILING && ctrlQ[3] && !pinFunctionSelect)[*4]
		|-> ##[0:315] !callProgressOut) else $error("no fall in period");
endmodule
`default_nettype wire

//--- dv/cpac_speaker_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpac_speaker_model (
	// clock and window control
	input wire logic  clk,
	input wire logic  clear,
	// pin
	input wire logic  pwmIn,
	input wire logic  pwmEn,
	// integrated level
	output logic [15:0] onesCount
);
	// the filter integrates driven highs; a released pin adds nothing
	always_ff @(posedge clk) begin
		if (clear)
			onesCount <= 16'h0000;
		else if (pwmIn && pwmEn)
			onesCount <= onesCount + 16'h0001;
	end
endmodule
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin n_errors++; \
	$display("FAIL %s exp %0h got %0h", n, e, a); end end
module tb_top;
	import cpac_pkg::*;
	logic clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, spkClear = 1'b1;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, d;
	logic [15:0] txAudio = 16'h0000, rxAudio = 16'h0000, rxFilterIn, onesCount;
	logic [15:0] txFiltered = 16'h1234, linkRxData = 16'hABCD;
	logic pinFunctionSelect = 1'b0, interruptLevel = 1'b0;
	logic loopbackActive, callProgressOut, callProgressOutEn, softResetPulse;
	int n_errors = 0, check_count = 0;
	int lo[6] = '{312, 312, 312, 390, 390, 234};
	int hi[6] = '{313, 312, 312, 391, 390, 234};
	always #50 clk = ~clk;
	cpac_top i_cpac_top (.clk, .rst, .regAddr, .regWdata, .regWrite, .regRead, .regRdata,
		.txAudio, .rxAudio, .txFiltered, .linkRxData, .rxFilterIn, .loopbackActive,
		.pinFunctionSelect, .interruptLevel, .callProgressOut, .callProgressOutEn,
		.softResetPulse);
	cpac_speaker_model i_cpac_speaker_model (.clk, .clear(spkClear), .pwmIn(callProgressOut),
		.pwmEn(callProgressOutEn), .onesCount);
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regWdata <= v;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 v = regRdata;
	endtask
	// settle past one full period, then count driven highs over a window
	task automatic measure(input int w, input int l, input int h);
		repeat (700) @(posedge clk);
		spkClear <= 1'b1;
		@(posedge clk);
		spkClear <= 1'b0;
		repeat (w) @(posedge clk);
		#1 `CHK("ones", 1'b1, (onesCount >= l) && (onesCount <= h))
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (15000) @(posedge clk);
		n_errors++;
		wrap_up();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		wr(8'h01, 8'h7F);
		rd(8'h01, d);
		`CHK("ctrl", 8'h3A, d)
		wr(8'h02, 8'hFF);
		rd(8'h02, d);
		`CHK("unmapped", 8'h00, d)
		wr(8'h01, 8'h80);
		#1 `CHK("pulse", 1'b1, softResetPulse)
		rd(8'h01, d);
		`CHK("ctrl", 8'h00, d)
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			txAudio <= (i < 3) ? 16'h0000 : 16'h2000;
			rxAudio <= (i < 3) ? 16'h0000 : 16'h2000;
			wr(8'h01, 8'h08 | 8'((i % 3) << 4));
			measure((i % 3 == 2) ? 624 : 625, lo[i], hi[i]);
		end
		wr(8'h01, 8'h38);
		measure(625, 0, 0);
		`CHK("en", 1'b1, callProgressOutEn)
		wr(8'h01, 8'h10);
		measure(625, 0, 0);
		`CHK("en", 1'b0, callProgressOutEn)
		@(posedge clk);
		pinFunctionSelect <= 1'b1;
		interruptLevel <= 1'b1;
		repeat (2) @(posedge clk);
		#1 `CHK("pin", 1'b1, callProgressOut)
		`CHK("pinEn", 1'b1, callProgressOutEn)
		// line side taken as powered and off-hook here
		wr(8'h01, 8'h02);
		repeat (2) @(posedge clk);
		#1 `CHK("loop", 1'b1, loopbackActive)
		`CHK("rxIn", 16'h1234, rxFilterIn)
		wr(8'h01, 8'h00);
		repeat (2) @(posedge clk);
		#1 `CHK("rxIn", 16'hABCD, rxFilterIn)
		wrap_up();
	end
endmodule
bind cpac_top cpac_checker i_cpac_checker (.clk, .rst, .regAddr, .regWdata, .regWrite,
	.regRead, .regRdata, .txAudio, .rxAudio, .txFiltered, .linkRxData, .rxFilterIn,
	.loopbackActive, .pinFunctionSelect, .interruptLevel, .callProgressOut,
	.callProgressOutEn, .softResetPulse);
`default_nettype wire
